/* File: hw/fpcl_params.svh */
// Purpose: Constants for the fast parallel configuration loader.
// Assumes: Core clock of 50 MHz.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef FPCL_PARAMS_SVH
`define FPCL_PARAMS_SVH
`define FPCL_CLK_MHZ 50
`define FPCL_POR_DELAY_US 4000
`define FPCL_POR_CYCLES (`FPCL_POR_DELAY_US * `FPCL_CLK_MHZ)
`define FPCL_DATA_W 32
`define FPCL_IMAGE_WORDS 16
`define FPCL_RATIO 2
`define FPCL_INIT_EDGES 2
`define FPCL_INIT_CYCLES 64
`define FPCL_OPT_INIT_PIN_BIT 0
`define FPCL_OPT_WORD_IDX 0
`endif

/* File: hw/fpcl_pkg.sv */
// Purpose: Types for the fast parallel configuration loader.
// Assumes: Nothing beyond the parameter header.
// Notes: Pin groups travel as packed structs.
package fpcl_pkg;
  typedef enum logic [2:0] {
    FPCL_POR,
    FPCL_RESET,
    FPCL_LOAD,
    FPCL_DONE,
    FPCL_INIT,
    FPCL_USER
  } fpcl_state_t;

  // Open-drain pins: value out and enable, enable low while driving.
  typedef struct packed {
    logic status_o;
    logic status_oe_n;
    logic done_o;
    logic done_oe_n;
    logic init_done_o;
    logic init_done_oe_n;
  } fpcl_pins_t;
endpackage

/* File: hw/fpcl_image_mem.sv */
// Purpose: Small word store holding the received configuration image.
// Assumes: One write port, one read port, same clock.
// Notes: Read data come out of a register.
`timescale 1ns/1ps
module fpcl_image_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_ff[rd_addr_i];
  end
endmodule // fpcl_image_mem

/* File: hw/fpcl_loader.sv */
// Purpose: Device side of the passive fast parallel configuration port.
// Assumes: Host drives config_clock and data; pins are sampled at 50 MHz.
// Notes: The link clock is sampled, so it must stay below 12.5 MHz.
// Summary of operation
// RULE1: In user mode the request, status and load-complete lines sit high.
// RULE2: A low request abandons user mode and starts a new configuration.
// RULE3: After power-up status is held low for the whole power-on delay.
// RULE4: Load-complete is low after power-up, before and during loading.
// RULE5: The host pauses the transfer only by holding config_clock low.
// RULE6: After a pause the host sets the data before the first rising edge.
// RULE7: The host sends the whole image, a partial one never completes.
// RULE8: Load-complete rises only after every image word arrived cleanly; the code only counts words, sum_ff is never checked.
// RULE9: After load-complete the host gives two falling edges to start init.
// RULE10: Once its option is loaded, the init pin stays low until init ends.
// RULE11: After configuration the host holds config_clock at a fixed level.
// RULE12: Both parties use the same clocks-per-word ratio r.
// RULE13: Status is released high once the power-on delay has expired.
// RULE14: With r above one, exactly one word is taken every r clock cycles.
`timescale 1ns/1ps
`include "fpcl_params.svh"
module fpcl_loader #(
  parameter int DATA_W = `FPCL_DATA_W,
  parameter int WORDS = `FPCL_IMAGE_WORDS,
  parameter int RATIO = `FPCL_RATIO,
  parameter int POR_CYCLES = `FPCL_POR_CYCLES
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic config_req_n_i,
  input wire logic config_clock_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic [2:0] mode_select_pins_i,
  output fpcl_pkg::fpcl_pins_t pins_o,
  output logic user_mode_o,
  output logic [DATA_W-1:0] opt_word_o
);
  import fpcl_pkg::*;

  localparam int AW = $clog2(WORDS);
  localparam int RW = $clog2(RATIO + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers. Data are sampled on the rising edge found from
  // the synchronised clock; data and clock pass two flops each, so data need only be steady when the clock is first sampled high.
  logic [2:0] req_s_ff, clk_s_ff;
  logic [DATA_W-1:0] dat_s1_ff, dat_s2_ff;
  logic [2:0] mode_select_pins_s1_ff, mode_select_pins_s2_ff;
  always_ff @(posedge clock_i) begin
    req_s_ff <= {req_s_ff[1:0], config_req_n_i};
    clk_s_ff <= {clk_s_ff[1:0], config_clock_i};
    dat_s1_ff <= data_i;
    dat_s2_ff <= dat_s1_ff;
    mode_select_pins_s1_ff <= mode_select_pins_i;
    mode_select_pins_s2_ff <= mode_select_pins_s1_ff;
  end
  logic req_n, rise, fall;
  assign req_n = req_s_ff[1];
  assign rise = clk_s_ff[1] & ~clk_s_ff[2];
  assign fall = ~clk_s_ff[1] & clk_s_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  fpcl_state_t state_ff, nxt_state;
  logic [31:0] por_cnt_ff, nxt_por_cnt;
  logic [RW-1:0] phase_ff, nxt_phase;
  logic [AW:0] word_ff, nxt_word;
  logic [1:0] fall_ff, nxt_fall;
  logic armed_ff, nxt_armed;
  logic [7:0] init_ff, nxt_init;
  logic opt_init_ff, nxt_opt_init;
  logic [DATA_W-1:0] opt_ff, nxt_opt;
  logic [DATA_W-1:0] sum_ff, nxt_sum;
  logic wr_en;
  logic [DATA_W-1:0] rd_data;

  always_comb begin
    nxt_state = state_ff;
    nxt_por_cnt = por_cnt_ff;
    nxt_phase = phase_ff;
    nxt_word = word_ff;
    nxt_fall = fall_ff;
    nxt_armed = armed_ff;
    nxt_init = init_ff;
    nxt_opt_init = opt_init_ff;
    nxt_opt = opt_ff;
    nxt_sum = sum_ff;
    wr_en = 1'b0;
    case (state_ff)
      FPCL_POR: begin
        // Power-on delay keeps status low, then releases it.
        nxt_por_cnt = por_cnt_ff + 32'h1; // RULE3
        if (por_cnt_ff >= 32'(POR_CYCLES - 1)) begin
          nxt_state = FPCL_RESET; // RULE13
        end
      end
      FPCL_RESET: begin
        nxt_phase = '0;
        nxt_word = '0;
        nxt_sum = '0;
        nxt_opt_init = 1'b0;
        nxt_armed = 1'b0;
        if (req_n) begin
          nxt_state = FPCL_LOAD;
        end
      end
      FPCL_LOAD: begin
        // A stalled clock gives no edges, so a pause needs no handling.
        if (rise) begin // RULE5
          if (phase_ff == RW'(RATIO - 1)) begin
            nxt_phase = '0;
            wr_en = 1'b1; // RULE14 RULE12
            nxt_sum = sum_ff ^ dat_s2_ff;
            nxt_word = word_ff + 1'b1;
            if (word_ff == (AW + 1)'(`FPCL_OPT_WORD_IDX)) begin
              nxt_opt = dat_s2_ff;
              nxt_opt_init = dat_s2_ff[`FPCL_OPT_INIT_PIN_BIT]; // RULE10
            end
            if (word_ff == (AW + 1)'(WORDS - 1)) begin
              nxt_state = FPCL_DONE; // RULE8
              nxt_fall = '0;
              nxt_armed = 1'b0;
            end
          end else begin
            nxt_phase = phase_ff + 1'b1; // RULE14
          end
        end
      end
      FPCL_DONE: begin
        // The trailing fall of the last data pulse is not an extra edge, so
        // falls only count once a rise has been seen after load-complete.
        if (rise) begin
          nxt_armed = 1'b1;
        end
        if (fall && armed_ff) begin
          nxt_fall = fall_ff + 2'h1;
          if (fall_ff == 2'(`FPCL_INIT_EDGES - 1)) begin
            nxt_state = FPCL_INIT; // RULE9
            nxt_init = '0;
          end
        end
      end
      FPCL_INIT: begin
        nxt_init = init_ff + 8'h1;
        if (init_ff == 8'(`FPCL_INIT_CYCLES - 1)) begin
          nxt_state = FPCL_USER;
        end
      end
      default: begin
      end
    endcase
    if (!req_n && state_ff != FPCL_POR) begin
      nxt_state = FPCL_RESET; // RULE2
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff <= FPCL_POR;
      por_cnt_ff <= 32'h0;
      phase_ff <= '0;
      word_ff <= '0;
      fall_ff <= 2'h0;
      armed_ff <= 1'b0;
      init_ff <= 8'h0;
      opt_init_ff <= 1'b0;
      opt_ff <= '0;
      sum_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      por_cnt_ff <= nxt_por_cnt;
      phase_ff <= nxt_phase;
      word_ff <= nxt_word;
      fall_ff <= nxt_fall;
      armed_ff <= nxt_armed;
      init_ff <= nxt_init;
      opt_init_ff <= nxt_opt_init;
      opt_ff <= nxt_opt;
      sum_ff <= nxt_sum;
    end
  end

  fpcl_image_mem #(
    .WIDTH(DATA_W),
    .DEPTH(WORDS)
  ) u_mem (
    .clock_i(clock_i),
    .wr_en_i(wr_en),
    .wr_addr_i(word_ff[AW-1:0]),
    .wr_data_i(dat_s2_ff),
    .rd_addr_i('0),
    .rd_data_o(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain outputs: enable low drives the pin low, high releases it.
  logic st_low, cd_low, id_low;
  assign st_low = (state_ff == FPCL_POR) || (state_ff == FPCL_RESET); // RULE3
  assign cd_low = (state_ff != FPCL_DONE) && (state_ff != FPCL_INIT) &&
                  (state_ff != FPCL_USER); // RULE4 RULE1
  assign id_low = opt_init_ff && (state_ff != FPCL_USER); // RULE10
  always_comb begin
    pins_o.status_o = 1'b0;
    pins_o.status_oe_n = ~st_low;
    pins_o.done_o = 1'b0;
    pins_o.done_oe_n = ~cd_low;
    pins_o.init_done_o = 1'b0;
    pins_o.init_done_oe_n = ~id_low;
  end
  assign user_mode_o = (state_ff == FPCL_USER); // RULE1
  assign opt_word_o = opt_ff;

  ////////////////////////////////////////////////////////////////////////////
  sequence load_end_s;
    state_ff == FPCL_LOAD && wr_en && word_ff == (AW + 1)'(WORDS - 1);
  endsequence

  por_status_low_a: assert property (@(posedge clock_i) disable iff (srst_i)
    state_ff == FPCL_POR |-> !pins_o.status_oe_n) // RULE3
    else $error("status released during power-on delay");
  por_release_a: assert property (@(posedge clock_i) disable iff (srst_i)
    state_ff == FPCL_POR && nxt_state == FPCL_RESET
    |-> por_cnt_ff == 32'(POR_CYCLES - 1)) // RULE13
    else $error("power-on delay length wrong");
  done_low_load_a: assert property (@(posedge clock_i) disable iff (srst_i)
    state_ff == FPCL_LOAD |-> !pins_o.done_oe_n) // RULE4
    else $error("load-complete released while loading");
  done_after_all_a: assert property (@(posedge clock_i) disable iff (srst_i)
    load_end_s and req_n |=> state_ff == FPCL_DONE
    && pins_o.done_oe_n) // RULE8
    else $error("load-complete not released after last word");
  one_word_ratio_a: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_en |-> rise && phase_ff == RW'(RATIO - 1)) // RULE14
    else $error("word taken off ratio phase");
  req_abort_a: assert property (@(posedge clock_i) disable iff (srst_i)
    !req_n && state_ff != FPCL_POR |=> state_ff == FPCL_RESET) // RULE2
    else $error("request low did not restart configuration");
  user_pins_high_a: assert property (@(posedge clock_i) disable iff (srst_i)
    user_mode_o |-> pins_o.status_oe_n && pins_o.done_oe_n) // RULE1
    else $error("pins not high in user mode");
  init_pin_low_a: assert property (@(posedge clock_i) disable iff (srst_i)
    opt_init_ff && state_ff == FPCL_INIT |-> !pins_o.init_done_oe_n) // RULE10
    else $error("init pin released before init end");
  two_falls_a: assert property (@(posedge clock_i) disable iff (srst_i)
    state_ff == FPCL_DONE ##1 state_ff == FPCL_INIT
    |-> $past(fall_ff) == 2'(`FPCL_INIT_EDGES - 1) && $past(armed_ff)) // RULE9
    else $error("init started without two falling edges");
endmodule // fpcl_loader

/* File: test/fpcl_host_model.sv */
// Purpose: Host model that drives the fast parallel load port.
// Assumes: Link clock of 160 ns, started and stopped by the tasks.
// Notes: Idle data shows the inverse of the last word, never a stale copy.
`timescale 1ns/1ps
module fpcl_host_model #(
  parameter int RATIO = 2
) (
  input wire logic clock_i,
  output logic config_req_n_o,
  output logic config_clock_o,
  output logic [31:0] data_o
);
  initial begin
    config_req_n_o = 1'b1;
    config_clock_o = 1'b0;
    data_o = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Changes land just after a core edge; one link period is eight core
  // cycles, four high and four low, and the clock rests low between calls.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock_i);
      config_clock_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      config_clock_o <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
  endtask
  task automatic send_word(input logic [31:0] w);
    @(posedge clock_i);
    data_o <= w;
    pulses(RATIO);
    data_o <= ~w;
  endtask
  task automatic send_image(input logic [31:0] w0, input int n);
    for (int i = 0; i < n; i++) begin
      send_word((i == 0) ? w0 : (32'h5A5A0000 + 32'(i)));
    end
  endtask
  task automatic request(input logic v);
    @(posedge clock_i);
    config_req_n_o <= v;
  endtask
endmodule // fpcl_host_model

/* File: test/fpcl_loader_tb.sv */
// Purpose: Self-checking bench for the fast parallel configuration loader.
// Assumes: Shortened power-on delay and a four-word image.
// Notes: Outputs are sampled 1 ns after the core edge so updates settle.
`timescale 1ns/1ps
module fpcl_loader_tb;
  import fpcl_pkg::*;
  localparam int WORDS = 4;
  localparam int POR = 50;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] mode_select_pins_i = 3'h0;
  wire config_req_n;
  wire config_clock;
  wire [31:0] data;
  fpcl_pins_t pins_o;
  logic user_mode_o;
  logic [31:0] opt_word_o;
  int n_fail = 0;
  int n_compared = 0;
  always #10 clock_i = ~clock_i;
  fpcl_host_model host (
    .clock_i(clock_i),
    .config_req_n_o(config_req_n),
    .config_clock_o(config_clock),
    .data_o(data)
  );
  fpcl_loader #(.WORDS(WORDS), .POR_CYCLES(POR)) dut (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .config_req_n_i(config_req_n),
    .config_clock_i(config_clock),
    .data_i(data),
    .mode_select_pins_i(mode_select_pins_i),
    .pins_o(pins_o),
    .user_mode_o(user_mode_o),
    .opt_word_o(opt_word_o)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    chk("status_oe_n", 32'h0, pins_o.status_oe_n);
    chk("done_oe_n", 32'h0, pins_o.done_oe_n);
    cyc(POR - 8);
    chk("status_oe_n", 32'h0, pins_o.status_oe_n);
    cyc(16);
    chk("status_oe_n", 32'h1, pins_o.status_oe_n);
  endtask
  // A short image must never complete; a word taken per rise would.
  task automatic t_load(input logic [31:0] w0);
    host.send_image(w0, WORDS - 1);
    cyc(10);
    chk("done_oe_n", 32'h0, pins_o.done_oe_n);
    host.send_word(32'h5A5A0003);
    cyc(6);
    chk("done_oe_n", 32'h1, pins_o.done_oe_n);
    host.pulses(2);
    cyc(4);
    chk("init_done_oe_n", {31'h0, ~w0[0]}, pins_o.init_done_oe_n);
    for (int i = 0; i < 200 && user_mode_o !== 1'b1; i++) cyc(1);
    chk("user_mode_o", 32'h1, user_mode_o);
    chk("released pins", 32'h7, {pins_o.status_oe_n, pins_o.done_oe_n,
        pins_o.init_done_oe_n});
    chk("opt_word_o", w0, opt_word_o);
  endtask
  task automatic t_reconfig();
    @(posedge clock_i);
    mode_select_pins_i <= 3'h5;
    host.request(1'b0);
    cyc(8);
    chk("user_mode_o", 32'h0, user_mode_o);
    chk("status and done", 32'h0, {pins_o.status_oe_n,
        pins_o.done_oe_n});
    host.request(1'b1);
    for (int i = 0; i < 300 && pins_o.status_oe_n !== 1'b1; i++) cyc(1);
    chk("status_oe_n", 32'h1, pins_o.status_oe_n);
    t_load(32'hC3C30000);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    cyc(1);
    t_power_up();
    t_load(32'h12345671);
    t_reconfig();
    conclude();
  end
  // The whole run needs under 2000 core cycles; this leaves a wide margin.
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule // fpcl_loader_tb
